// file: logic/cbtrf_pkg.sv
// Constants, types and helpers of the CAN bit timing and receive flag block.
// Assumes a 32-bit AHB-Lite slave with one register per aligned word.
package cbtrf_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_PRESCALE = 8'h04;
  localparam logic [7:0] OFS_SEGMENT  = 8'h08;
  localparam logic [7:0] OFS_FLAGS    = 8'h0c;
  localparam logic [7:0] OFS_IER      = 8'h10;
  localparam logic [7:0] OFS_STATUS   = 8'h14;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_SOFT_RESET = 0;
  localparam int PRESC_LSB       = 0;
  localparam int PRESC_MSB       = 5;
  localparam int SEG1_LSB        = 0;
  localparam int SEG1_MSB        = 3;
  localparam int SEG2_LSB        = 4;
  localparam int SEG2_MSB        = 6;
  localparam int SEG_MAJORITY    = 7;
  localparam int FLAG_WAKE       = 7;
  localparam int FLAG_RX_WARN    = 6;
  localparam int FLAG_TX_WARN    = 5;
  localparam int FLAG_RX_PASSIVE = 4;
  localparam int FLAG_TX_PASSIVE = 3;
  localparam int FLAG_BUS_OFF    = 2;
  localparam int FLAG_OVERRUN    = 1;
  localparam int FLAG_RX_FULL    = 0;
  localparam int STAT_REC_LSB    = 0;
  localparam int STAT_TEC_LSB    = 8;
  localparam int STAT_SYNCH      = 24;

  // ****************************************
  // Reset values and masks
  // ****************************************
  localparam logic [7:0] CTRL_RST     = 8'h01;
  localparam logic [7:0] PRESCALE_RST = 8'h00;
  localparam logic [7:0] SEGMENT_RST  = 8'h00;
  localparam logic [7:0] FLAGS_RST    = 8'h00;
  localparam logic [7:0] IER_RST      = 8'h00;
  localparam logic [7:0] ERR_MASK     = 8'h7e;

  // ****************************************
  // Error thresholds and recovery counts
  // ****************************************
  localparam logic [8:0] WARN_LIMIT    = 9'h060;
  localparam logic [8:0] PASSIVE_LIMIT = 9'h07f;
  localparam logic [8:0] BUS_OFF_LIMIT = 9'h0ff;
  localparam logic [3:0] RECESSIVE_RUN = 4'hb;
  localparam int         RECOVERY_RUNS = 128;

  // ****************************************
  // Bus slave states
  // ****************************************
  typedef enum logic [0:0] {
    CBTRF_BUS_IDLE = 1'b0,
    CBTRF_BUS_READ = 1'b1
  } cbtrf_bus_st_t;

  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction

endpackage

// file: logic/cbtrf_bit_timer.sv
// Time-quantum prescaler and bit sampler.
// Assumes rx is already synchronised to hclk; run low holds it idle.
`timescale 1ns/1ps
module cbtrf_bit_timer (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       run,
  input  wire logic [5:0] prescale,
  input  wire logic [3:0] tseg1,
  input  wire logic [2:0] tseg2,
  input  wire logic       triple,
  input  wire logic       rx,
  output logic            tq_tick,
  output logic            sample_valid,
  output logic            sample_bit
);

  logic [5:0] pre_cnt;
  logic [4:0] quanta;
  logic [1:0] hist;

  // ****************************************
  // Decode
  // ****************************************
  wire       pre_end   = (pre_cnt == prescale);
  wire [4:0] seg1_end  = 5'(tseg1) + 5'h01;
  wire [4:0] bit_end   = seg1_end + 5'(tseg2) + 5'h01;
  wire       at_sample = pre_end && (quanta == seg1_end);
  wire       voted     = cbtrf_pkg::maj3(hist[1], hist[0], rx);
  wire       next_bit  = triple ? voted : rx;

  // ****************************************
  // Counters
  // ****************************************
  // Bit length is sync quantum plus both segments, each quantum prescale+1 clocks
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pre_cnt      <= 6'h00;
      quanta       <= 5'h00;
      hist         <= 2'h3;
      tq_tick      <= 1'b0;
      sample_valid <= 1'b0;
      sample_bit   <= 1'b1;
    end
    else if (!run)
    begin
      pre_cnt      <= 6'h00;
      quanta       <= 5'h00;
      hist         <= 2'h3;
      tq_tick      <= 1'b0;
      sample_valid <= 1'b0;
      sample_bit   <= 1'b1;
    end
    else
    begin
      pre_cnt <= pre_end ? 6'h00 : pre_cnt + 6'h01;
      tq_tick <= pre_end;
      if (pre_end)
      begin
        quanta <= (quanta == bit_end) ? 5'h00 : quanta + 5'h01;
        hist   <= {hist[0], rx};
      end
      sample_valid <= at_sample;
      if (at_sample)
        sample_bit <= next_bit;
    end
  end

endmodule

// file: logic/cbtrf_top.sv
// CAN bit timing configuration and receiver flag/interrupt logic.
// Assumes an AHB-Lite master, a frame engine on hclk, can_rx from a pin.
`timescale 1ns/1ps
module cbtrf_top #(
  parameter int RECOVERY_RUNS = cbtrf_pkg::RECOVERY_RUNS
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        can_rx,
  input  wire logic [7:0]  rx_error_counter,
  input  wire logic [8:0]  tx_error_counter,
  input  wire logic        sleep_mode,
  input  wire logic        overrun_event,
  input  wire logic        bg_msg_ready,
  output logic             fg_load,
  output logic             soft_reset_out,
  output logic             bus_synced,
  output logic             tq_tick,
  output logic             sample_valid,
  output logic             sample_bit,
  output logic             wake_irq,
  output logic             rx_irq,
  output logic             err_irq
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  generate
    if (RECOVERY_RUNS < 1 || RECOVERY_RUNS > 255)
    begin : g_bad_runs
      $error("RECOVERY_RUNS must lie in 1..255");
    end
  endgenerate

  localparam logic [7:0] RUNS = 8'(RECOVERY_RUNS);

  // ****************************************
  // Registers and state
  // ****************************************
  cbtrf_pkg::cbtrf_bus_st_t bus_st;
  logic [7:0]  ctrl;
  logic [7:0]  prescale_reg;
  logic [7:0]  segment_reg;
  logic [7:0]  flags;
  logic [7:0]  ier;
  logic        wr_pend;
  logic [7:0]  addr_q;
  logic        rx_meta;
  logic        rx_sync;
  logic        rx_prev;
  logic [3:0]  run_cnt;
  logic [7:0]  recov_cnt;
  logic        bt_tq;
  logic        bt_valid;
  logic        bt_bit;

  // ****************************************
  // Bus decode
  // ****************************************
  wire        soft_rst  = ctrl[cbtrf_pkg::CTRL_SOFT_RESET];
  wire        addr_ok   = hsel && htrans[1] && hready && (bus_st == cbtrf_pkg::CBTRF_BUS_IDLE);
  wire        take_wr   = addr_ok && hwrite && (hsize == 3'h2);
  wire        take_rd   = addr_ok && !hwrite;
  wire [7:0]  wdat      = hwdata[7:0];
  wire        wr_ctrl   = wr_pend && (addr_q == cbtrf_pkg::OFS_CTRL);
  wire        wr_presc  = wr_pend && (addr_q == cbtrf_pkg::OFS_PRESCALE) && soft_rst;
  wire        wr_seg    = wr_pend && (addr_q == cbtrf_pkg::OFS_SEGMENT) && soft_rst;
  wire        wr_flags  = wr_pend && (addr_q == cbtrf_pkg::OFS_FLAGS);
  wire        wr_ier    = wr_pend && (addr_q == cbtrf_pkg::OFS_IER);

  // Unmapped words read as zero; writes to them are dropped
  wire [31:0] status_w  = {7'h00, bus_synced, 7'h00, tx_error_counter, rx_error_counter};
  wire [31:0] rd_mux    = (addr_q == cbtrf_pkg::OFS_CTRL)     ? {24'h000000, ctrl} :
                          (addr_q == cbtrf_pkg::OFS_PRESCALE) ? {24'h000000, prescale_reg} :
                          (addr_q == cbtrf_pkg::OFS_SEGMENT)  ? {24'h000000, segment_reg} :
                          (addr_q == cbtrf_pkg::OFS_FLAGS)    ? {24'h000000, flags} :
                          (addr_q == cbtrf_pkg::OFS_IER)      ? {24'h000000, ier} :
                          (addr_q == cbtrf_pkg::OFS_STATUS)   ? status_w :
                          32'h00000000;

  // ****************************************
  // Flag conditions
  // ****************************************
  wire f_rerr = flags[cbtrf_pkg::FLAG_RX_PASSIVE];
  wire f_terr = flags[cbtrf_pkg::FLAG_TX_PASSIVE];
  wire f_boff = flags[cbtrf_pkg::FLAG_BUS_OFF];
  wire f_rxf  = flags[cbtrf_pkg::FLAG_RX_FULL];
  wire [8:0] rec9 = {1'b0, rx_error_counter};

  wire c_rwrn = (rec9 > cbtrf_pkg::WARN_LIMIT) && !f_rerr && !f_terr && !f_boff;
  wire c_twrn = (tx_error_counter > cbtrf_pkg::WARN_LIMIT) && !f_rerr && !f_terr
                && !f_boff;
  wire c_rerr = (rec9 > cbtrf_pkg::PASSIVE_LIMIT) && !f_boff;
  wire c_terr = (tx_error_counter > cbtrf_pkg::PASSIVE_LIMIT) && !f_boff;
  wire c_boff = (tx_error_counter > cbtrf_pkg::BUS_OFF_LIMIT);
  wire recov_done = (recov_cnt == RUNS);
  wire c_wake = sleep_mode && rx_prev && !rx_sync;
  wire load_now = bg_msg_ready && !f_rxf && !soft_rst;

  wire [7:0] set_v  = {c_wake, c_rwrn, c_twrn, c_rerr, c_terr, c_boff,
                       overrun_event, load_now};
  // Pulse-set flags have no lasting condition; bus-off also waits on recovery
  wire [7:0] hold_v = {1'b0, c_rwrn, c_twrn, c_rerr, c_terr,
                       c_boff || !recov_done, 1'b0, 1'b0};
  wire [7:0] clr_v  = wr_flags ? (wdat & ~hold_v) : 8'h00;
  // Set is ORed last so an event in the clearing cycle survives
  wire [7:0] next_flags = soft_rst ? cbtrf_pkg::FLAGS_RST : ((flags & ~clr_v) | set_v);

  wire [7:0] next_ier = soft_rst ? cbtrf_pkg::IER_RST : (wr_ier ? wdat : ier);

  // ****************************************
  // Recessive run detection
  // ****************************************
  wire run_hit = bt_valid && bt_bit && (run_cnt == cbtrf_pkg::RECESSIVE_RUN - 4'h1);
  wire [3:0] next_run = !bt_valid ? run_cnt :
                        (!bt_bit || run_hit) ? 4'h0 : run_cnt + 4'h1;

  // ****************************************
  // Bit timer
  // ****************************************
  // Holding the timer idle in soft reset aborts any frame and drops sync
  cbtrf_bit_timer u_bit_timer (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .run          (!soft_rst),
    .prescale     (prescale_reg[cbtrf_pkg::PRESC_MSB:cbtrf_pkg::PRESC_LSB]),
    .tseg1        (segment_reg[cbtrf_pkg::SEG1_MSB:cbtrf_pkg::SEG1_LSB]),
    .tseg2        (segment_reg[cbtrf_pkg::SEG2_MSB:cbtrf_pkg::SEG2_LSB]),
    .triple       (segment_reg[cbtrf_pkg::SEG_MAJORITY]),
    .rx           (rx_sync),
    .tq_tick      (bt_tq),
    .sample_valid (bt_valid),
    .sample_bit   (bt_bit)
  );

  // ****************************************
  // Pin synchroniser
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
      rx_prev <= 1'b1;
    end
    else
    begin
      rx_meta <= can_rx;
      rx_sync <= rx_meta;
      rx_prev <= rx_sync;
    end
  end

  // ****************************************
  // Bus slave
  // ****************************************
  // Reads take one wait state so a write just ahead is already visible
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus_st    <= cbtrf_pkg::CBTRF_BUS_IDLE;
      wr_pend   <= 1'b0;
      addr_q    <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h00000000;
    end
    else
    begin
      wr_pend <= take_wr;
      if (addr_ok)
        addr_q <= haddr[7:0];
      case (bus_st)
        cbtrf_pkg::CBTRF_BUS_IDLE:
        begin
          if (take_rd)
          begin
            bus_st    <= cbtrf_pkg::CBTRF_BUS_READ;
            hreadyout <= 1'b0;
          end
        end
        cbtrf_pkg::CBTRF_BUS_READ:
        begin
          bus_st    <= cbtrf_pkg::CBTRF_BUS_IDLE;
          hrdata    <= rd_mux;
          hreadyout <= 1'b1;
        end
        default:
        begin
          bus_st    <= cbtrf_pkg::CBTRF_BUS_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl         <= cbtrf_pkg::CTRL_RST;
      prescale_reg <= cbtrf_pkg::PRESCALE_RST;
      segment_reg  <= cbtrf_pkg::SEGMENT_RST;
      ier          <= cbtrf_pkg::IER_RST;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= {7'h00, wdat[cbtrf_pkg::CTRL_SOFT_RESET]};
      if (wr_presc)
        prescale_reg <= wdat;
      if (wr_seg)
        segment_reg <= wdat;
      ier <= next_ier;
    end
  end

  // ****************************************
  // Status flags and recovery
  // ****************************************
  // Error counters come from outside and are never touched by soft reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      flags      <= cbtrf_pkg::FLAGS_RST;
      run_cnt    <= 4'h0;
      recov_cnt  <= 8'h00;
      bus_synced <= 1'b0;
    end
    else
    begin
      flags   <= next_flags;
      run_cnt <= soft_rst ? 4'h0 : next_run;
      if (!f_boff)
        recov_cnt <= 8'h00;
      else if (run_hit && !recov_done)
        recov_cnt <= recov_cnt + 8'h01;
      if (soft_rst)
        bus_synced <= 1'b0;
      else if (run_hit && (!f_boff || recov_done))
        bus_synced <= 1'b1;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fg_load        <= 1'b0;
      soft_reset_out <= 1'b1;
      tq_tick        <= 1'b0;
      sample_valid   <= 1'b0;
      sample_bit     <= 1'b1;
      wake_irq       <= 1'b0;
      rx_irq         <= 1'b0;
      err_irq        <= 1'b0;
    end
    else
    begin
      fg_load        <= load_now;
      soft_reset_out <= soft_rst;
      tq_tick        <= bt_tq;
      sample_valid   <= bt_valid;
      sample_bit     <= bt_bit;
      wake_irq       <= flags[cbtrf_pkg::FLAG_WAKE] && ier[cbtrf_pkg::FLAG_WAKE];
      rx_irq         <= f_rxf && ier[cbtrf_pkg::FLAG_RX_FULL];
      err_irq        <= |(flags & ier & cbtrf_pkg::ERR_MASK);
    end
  end

endmodule

// file: dv/cbtrf_assertions.sv
// Port-level checker of the CAN bit timing and receive flag block.
// Assumes one bus master, with hready tied back to hreadyout.
`timescale 1ns/1ps
module cbtrf_checker #(
  parameter int RECOVERY_RUNS = 128
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        fg_load,
  input wire logic        soft_reset_out,
  input wire logic        bus_synced,
  input wire logic        tq_tick,
  input wire logic        sample_valid,
  input wire logic        sample_bit,
  input wire logic        wake_irq,
  input wire logic        rx_irq,
  input wire logic        err_irq
);
  // ****************************************
  // Helpers
  // ****************************************
  wire  take = hsel && htrans[1] && hready;
  wire  clr  = take && hwrite && haddr[7:0] == cbtrf_pkg::OFS_FLAGS;
  logic open_ld;
  // Loose on purpose: any flag write reopens the foreground buffer
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      open_ld <= 1'b0;
    else
      open_ld <= (open_ld || fg_load) && !clr && !soft_reset_out;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ****************************************
  // Assertions
  // ****************************************
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("slave gave an error response");
  a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase not one wait state");
  a_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  a_fg_single: assert property (fg_load |-> !open_ld)
    else $error("foreground reloaded while still full");
  a_fg_held_off: assert property (soft_reset_out && $past(soft_reset_out) |-> !fg_load)
    else $error("foreground load during soft reset");
  a_irq_quiet: assert property (soft_reset_out |=> !(wake_irq || rx_irq || err_irq))
    else $error("interrupt raised during soft reset");
  a_sync_lost: assert property (soft_reset_out |=> !bus_synced)
    else $error("bus sync kept in soft reset");
  a_timer_idle: assert property (soft_reset_out [*4] |-> !tq_tick && !sample_valid)
    else $error("bit timer running in soft reset");
  a_sample_held: assert property ($changed(sample_bit) |-> sample_valid || soft_reset_out)
    else $error("sampled bit moved between sample points");

  c_load: cover property (fg_load);
  c_err: cover property ($rose(err_irq));
  c_sync: cover property ($rose(bus_synced));
  c_wake: cover property (wake_irq);
endmodule

bind cbtrf_top cbtrf_checker #(.RECOVERY_RUNS(RECOVERY_RUNS)) u_cbtrf_checker (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .fg_load(fg_load), .soft_reset_out(soft_reset_out), .bus_synced(bus_synced),
  .tq_tick(tq_tick), .sample_valid(sample_valid), .sample_bit(sample_bit),
  .wake_irq(wake_irq), .rx_irq(rx_irq), .err_irq(err_irq)
);

// file: dv/cbtrf_far_end.sv
// Frame engine and bus stand-in facing the receive flag block.
// Assumes the bench steers counts, bus level, sleep and message arrivals.
`timescale 1ns/1ps
module cbtrf_far_end (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       fg_load,
  input  wire logic [7:0] rec_set,
  input  wire logic [8:0] tec_set,
  input  wire logic       bus_level,
  input  wire logic       sleep_req,
  input  wire logic       msg_in,
  output logic            can_rx,
  output logic [7:0]      rx_error_counter,
  output logic [8:0]      tx_error_counter,
  output logic            sleep_mode,
  output logic            overrun_event,
  output logic            bg_msg_ready
);
  // Counters ignore soft reset on purpose
  assign rx_error_counter = rec_set;
  assign tx_error_counter = tec_set;
  assign can_rx = bus_level;
  assign sleep_mode = sleep_req;

  // New message over a full background buffer is lost
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      overrun_event <= 1'b0;
      bg_msg_ready <= 1'b0;
    end
    else
    begin
      overrun_event <= msg_in && bg_msg_ready && !fg_load;
      bg_msg_ready <= msg_in || (bg_msg_ready && !fg_load);
    end
endmodule

// file: dv/can_bit_timing_and_rx_flags_tb.sv
// Self-checking bench of the CAN bit timing and receive flag block.
// Assumes the far-end model and checker of dv/ and a 100 MHz hclk.
`timescale 1ns/1ps
module can_bit_timing_and_rx_flags_tb;
  localparam logic [7:0] CTL = cbtrf_pkg::OFS_CTRL;
  localparam logic [7:0] PRE = cbtrf_pkg::OFS_PRESCALE;
  localparam logic [7:0] SEG = cbtrf_pkg::OFS_SEGMENT;
  localparam logic [7:0] FLG = cbtrf_pkg::OFS_FLAGS;
  localparam logic [7:0] IER = cbtrf_pkg::OFS_IER;
  localparam logic [7:0] STA = cbtrf_pkg::OFS_STATUS;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  rec_set, rx_error_counter;
  logic [8:0]  tec_set, tx_error_counter;
  logic        bus_level, sleep_req, msg_in, can_rx, sleep_mode, overrun_event;
  logic        bg_msg_ready, fg_load, soft_reset_out, bus_synced, tq_tick;
  logic        sample_valid, sample_bit, wake_irq, rx_irq, err_irq;
  wire         hready = hreadyout;
  int          miscompares, check_count, loads, n, p, s1, s2;
  int          m_soft = 1, m_presc, m_seg, m_flags, m_ier, boff_lock = 1;
  int          recs[5] = '{97, 0, 128, 0, 0};
  int          tecs[5] = '{0, 97, 0, 128, 256};

  cbtrf_top #(.RECOVERY_RUNS(2)) u_cbtrf_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .can_rx(can_rx),
    .rx_error_counter(rx_error_counter), .tx_error_counter(tx_error_counter),
    .sleep_mode(sleep_mode), .overrun_event(overrun_event),
    .bg_msg_ready(bg_msg_ready), .fg_load(fg_load), .soft_reset_out(soft_reset_out),
    .bus_synced(bus_synced), .tq_tick(tq_tick), .sample_valid(sample_valid),
    .sample_bit(sample_bit), .wake_irq(wake_irq), .rx_irq(rx_irq), .err_irq(err_irq));
  cbtrf_far_end u_cbtrf_far_end (
    .hclk(hclk), .hresetn(hresetn), .fg_load(fg_load), .rec_set(rec_set),
    .tec_set(tec_set), .bus_level(bus_level), .sleep_req(sleep_req), .msg_in(msg_in),
    .can_rx(can_rx), .rx_error_counter(rx_error_counter),
    .tx_error_counter(tx_error_counter), .sleep_mode(sleep_mode),
    .overrun_event(overrun_event), .bg_msg_ready(bg_msg_ready));

  // ****************************************
  // Model and bus tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  function automatic int cond();
    int c;
    c = 0;
    if (tec_set > 255)
      c |= 8'h04;
    if (rec_set > 127 && !m_flags[2])
      c |= 8'h10;
    if (tec_set > 127 && !m_flags[2])
      c |= 8'h08;
    if (rec_set > 96 && (m_flags & 8'h1c) == 0)
      c |= 8'h40;
    if (tec_set > 96 && (m_flags & 8'h1c) == 0)
      c |= 8'h20;
    return c;
  endfunction
  // Called just after an edge; waits are cut only by the watchdog
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input int d);
    xfer(1'b1, a, d);
    if (a == CTL)
      m_soft = d & 1;
    if (a == PRE && m_soft)
      m_presc = d & 8'hff;
    if (a == SEG && m_soft)
      m_seg = d & 8'hff;
    if (a == IER && !m_soft)
      m_ier = d & 8'hff;
    if (a == FLG)
      m_flags &= ~(d & ~(cond() | (boff_lock << 2)));
    if (m_soft)
    begin
      m_flags = 0;
      m_ier = 0;
    end
  endtask
  task automatic rchk(input logic [7:0] a);
    int e;
    case (a)
      CTL: e = m_soft;
      PRE: e = m_presc;
      SEG: e = m_seg;
      FLG: e = m_flags;
      IER: e = m_ier;
      STA: e = {tec_set, rec_set};
      default: e = 0;
    endcase
    xfer(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  task automatic settle();
    repeat (4) @(posedge hclk);
    m_flags |= cond();
  endtask
  task automatic period(input logic sel, output int k);
    k = 0;
    do @(posedge hclk); while ((sel ? sample_valid : tq_tick) !== 1'b1);
    do
    begin
      @(posedge hclk);
      k++;
    end
    while ((sel ? sample_valid : tq_tick) !== 1'b1);
  endtask
  task automatic offer();
    msg_in <= 1'b1;
    @(posedge hclk);
    msg_in <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ****************************************
  // Clock, watchdog, counters
  // ****************************************
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial
  begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    $display("mismatch at %0t: watchdog expired", $time);
    wrap_up();
  end
  always @(posedge hclk)
    if (fg_load === 1'b1)
      loads++;

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    {hsel, hwrite, htrans, haddr, hwdata, msg_in, sleep_req} = '0;
    {hsize, rec_set, tec_set, bus_level, hresetn} = {3'h2, 8'h0, 9'h0, 1'b1, 1'b0};
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    void'($urandom(49416));
    for (int a = 0; a < 20; a += 4)
      rchk(a);
    rchk(8'h3c);
    $display("test reset values done");
    p = $urandom_range(3);
    s1 = $urandom_range(6, 3);
    s2 = $urandom_range(3, 1);
    wr(PRE, ($urandom_range(3) << 6) | p);
    wr(SEG, ($urandom_range(1) << 7) | (s2 << 4) | s1);
    rchk(PRE);
    rchk(SEG);
    wr(CTL, 0);
    period(1'b0, n);
    check(n, p + 1);
    period(1'b1, n);
    check(n, (p + 1) * (s1 + s2 + 3));
    wr(PRE, 8'h3f);
    rchk(PRE);
    wr(SEG, 8'h7f);
    rchk(SEG);
    bus_level <= 1'b0;
    period(1'b1, n);
    period(1'b1, n);
    check(sample_bit, 1'b0);
    $display("test bit timing done");
    wr(IER, 8'hff);
    for (int i = 0; i < 5; i++)
    begin
      rec_set <= recs[i];
      tec_set <= tecs[i];
      settle();
      rchk(FLG);
      check(err_irq, (m_flags & 8'h7e) != 0);
      wr(FLG, 8'hff);
      rchk(FLG);
    end
    tec_set <= 9'h0;
    settle();
    wr(FLG, 8'hff);
    rchk(FLG);
    bus_level <= 1'b1;
    repeat (2000) @(posedge hclk);
    boff_lock = 0;
    wr(FLG, 8'h04);
    rchk(FLG);
    check(bus_synced, 1'b1);
    $display("test error flags done");
    offer();
    m_flags |= 8'h01;
    check(rx_irq, 1'b1);
    offer();
    offer();
    m_flags |= 8'h02;
    rchk(FLG);
    check(loads, 1);
    wr(IER, 8'hfe);
    repeat (2) @(posedge hclk);
    check(rx_irq, 1'b0);
    wr(FLG, 8'h01);
    repeat (2) @(posedge hclk);
    m_flags |= 8'h01;
    rchk(FLG);
    check(loads, 2);
    wr(FLG, 8'h03);
    rchk(FLG);
    $display("test receive done");
    sleep_req <= 1'b1;
    @(posedge hclk);
    bus_level <= 1'b0;
    repeat (8) @(posedge hclk);
    m_flags |= 8'h80;
    rchk(FLG);
    check(wake_irq, 1'b1);
    sleep_req <= 1'b0;
    bus_level <= 1'b1;
    rec_set <= 8'h05;
    tec_set <= 9'h009;
    wr(CTL, 1);
    rchk(FLG);
    rchk(STA);
    check(wake_irq, 1'b0);
    wr(IER, 8'hff);
    rchk(IER);
    wr(CTL, 0);
    rchk(IER);
    $display("test soft reset done");
    wrap_up();
  end
endmodule
